// file: core/bst_tap.sv
// boundary-scan data paths, instructions, forced reset and debug mailbox
`timescale 1ns/1ps
`default_nettype none
module bst_tap
  import bst_pkg::*;
(
  // chip clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // test clock and tap controller strobes (test clock domain)
  input  wire logic                tck,
  input  wire logic                tap_reset,
  input  wire bst_tap_ctl_t        tap_ctl,
  input  wire logic                tdi,
  output logic                     tdo,
  output logic                     tdo_oe,
  // fuses and lock bits
  input  wire logic                test_port_enable_fuse,
  input  wire logic                debug_enable_fuse,
  input  wire logic                lock_bit_one,
  input  wire logic                lock_bit_two,
  input  wire logic                clk_opt_fuse,
  // fuse programming requests
  input  wire logic                dbg_fuse_prog_req,
  input  wire logic                chip_erase_done,
  output logic                     dbg_fuse_prog_grant,
  output logic                     dbg_fuse_prog_refused,
  // control and status register, disable bit
  input  wire logic                csr_wr,
  input  wire logic                csr_wdata_disable,
  output logic                     test_port_disable_bit,
  output logic                     tap_enabled,
  // cpu i/o access to the mailbox address
  input  wire bst_io_req_t         io_req,
  output logic [MBOX_W-1:0]        io_rdata,
  output logic                     io_pass_wr,
  output logic                     io_pass_rd,
  input  wire logic [MBOX_W-1:0]   io_pass_rdata,
  // debugger side of the mailbox (test clock domain)
  input  wire logic                dbg_access_en,
  input  wire logic                dbg_mbox_read,
  output logic [MBOX_W-1:0]        dbg_mbox_data,
  output logic                     dbg_mbox_dirty,
  // reset pin and device reset
  input  wire logic                ext_reset_n,
  output logic                     device_reset,
  // core side of port pins and analog interface
  input  wire logic [NUM_PINS-1:0] core_out,
  input  wire logic [NUM_PINS-1:0] core_oe,
  input  wire logic [NUM_PINS-1:0] core_pue,
  input  wire logic                core_ana_ctl,
  output logic [NUM_PINS-1:0]      core_in,
  output logic                     core_ana_in,
  // pad side of port pins and analog interface
  input  wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0]      pin_out,
  output logic [NUM_PINS-1:0]      pin_oe,
  output logic [NUM_PINS-1:0]      pin_pue,
  input  wire logic                ana_dig_in,
  output logic                     ana_dig_ctl
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // one bit in at the top, least significant bit out first
  function automatic logic [BS_LEN-1:0] shr_bs(input logic [BS_LEN-1:0] v, input logic b);
    shr_bs = {b, v[BS_LEN-1:1]};
  endfunction

  function automatic logic [ID_LEN-1:0] shr_id(input logic [ID_LEN-1:0] v, input logic b);
    shr_id = {b, v[ID_LEN-1:1]};
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [IR_W-1:0]     ir_shift_reg;
  bst_instr_t          ir_reg;
  logic                bypass_reg;
  logic [ID_LEN-1:0]   id_shift_reg;
  logic                rst_dr_reg;
  logic [BS_LEN-1:0]   bs_shift_reg;
  logic [BS_LEN-1:0]   bs_latch_reg;
  logic [BS_LEN-1:0]   bs_capture;
  logic                tap_en_tck;
  logic                sel_extest;
  logic                sel_bs;
  logic                dbg_read_tog_reg;
  logic [BS_LEN-1:0]   smp_raw;
  logic [BS_LEN-1:0]   smp_tck;
  logic [2:0]          sys_raw;
  logic [2:0]          sys_sync;
  logic                ext_rst_s;
  logic                dbg_acc_s;
  logic                read_tog_s;
  logic                read_tog_d_reg;
  logic                mbox_clear;
  logic [MBOX_W-1:0]   mbox_reg;
  logic                dirty_reg;
  logic                mbox_hit;
  logic                erased_reg;
  logic                rto_busy_reg;
  logic [RTO_W-1:0]    rto_cnt_reg;
  logic                rst_dr_meta_reg;
  logic                rst_dr_s;
  logic                hold_src;

  // ----------------------------------------------------------------
  // test port enable
  // ----------------------------------------------------------------
  // disable bit written by cpu
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      test_port_disable_bit <= 1'b0;
    end else if (csr_wr) begin
      test_port_disable_bit <= csr_wdata_disable;
    end
  end

  assign tap_enabled = test_port_enable_fuse & ~test_port_disable_bit;

  // enable level handed to the test clock domain
  bst_sync #(.WIDTH(1)) u_en_sync (
    .clk (tck),
    .d   (tap_enabled),
    .q   (tap_en_tck)
  );

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  // four-bit shift stage; unknown codes fall back to bypass
  always_ff @(posedge tck) begin
    if (tap_reset || !tap_en_tck) begin
      ir_shift_reg <= IR_CAPTURE_VAL;
      ir_reg       <= INS_IDCODE;
    end else begin
      if (tap_ctl.capture_ir) begin
        ir_shift_reg <= IR_CAPTURE_VAL;
      end else if (tap_ctl.shift_ir) begin
        ir_shift_reg <= {tdi, ir_shift_reg[IR_W-1:1]};
      end
      if (tap_ctl.update_ir) begin
        case (ir_shift_reg)
          INS_EXTEST:    ir_reg <= INS_EXTEST;
          INS_IDCODE:    ir_reg <= INS_IDCODE;
          INS_SAMPLE:    ir_reg <= INS_SAMPLE;
          INS_FORCE_RST: ir_reg <= INS_FORCE_RST;
          default:       ir_reg <= INS_BYPASS;
        endcase
      end
    end
  end

  assign sel_extest = (ir_reg == INS_EXTEST);
  assign sel_bs     = sel_extest || (ir_reg == INS_SAMPLE);

  // ----------------------------------------------------------------
  // bypass, identification and reset data registers
  // ----------------------------------------------------------------
  // bypass: one stage, zero out of capture
  always_ff @(posedge tck) begin
    if (tap_reset) begin
      bypass_reg <= 1'b0;
    end else if (ir_reg == INS_BYPASS && tap_ctl.capture_dr) begin
      bypass_reg <= 1'b0;
    end else if (ir_reg == INS_BYPASS && tap_ctl.shift_dr) begin
      bypass_reg <= tdi;
    end
  end

  // identification: fixed fields loaded at capture
  always_ff @(posedge tck) begin
    if (tap_reset) begin
      id_shift_reg <= '0;
    end else if (ir_reg == INS_IDCODE && tap_ctl.capture_dr) begin
      id_shift_reg <= '0;
      id_shift_reg[ID_LEN-1:ID_VER_LSB]       <= ID_VERSION;
      id_shift_reg[ID_VER_LSB-1:ID_PART_LSB]  <= ID_PART;
      id_shift_reg[ID_PART_LSB-1:ID_MFR_LSB]  <= ID_MFR;
      id_shift_reg[0]                         <= ID_MARKER;
    end else if (ir_reg == INS_IDCODE && tap_ctl.shift_dr) begin
      id_shift_reg <= shr_id(id_shift_reg, tdi);
    end
  end

  // reset register: output unlatched, reset follows it while shifting
  always_ff @(posedge tck) begin
    if (tap_reset) begin
      rst_dr_reg <= 1'b0;
    end else if (ir_reg == INS_FORCE_RST && tap_ctl.shift_dr) begin
      rst_dr_reg <= tdi;
    end
  end

  // ----------------------------------------------------------------
  // boundary chain
  // ----------------------------------------------------------------
  // pad and core levels reach the test clock only through two flops
  assign smp_raw = {ana_dig_in, core_ana_ctl,
                    core_pue[7], core_oe[7], pin_in[7], core_pue[6], core_oe[6], pin_in[6],
                    core_pue[5], core_oe[5], pin_in[5], core_pue[4], core_oe[4], pin_in[4],
                    core_pue[3], core_oe[3], pin_in[3], core_pue[2], core_oe[2], pin_in[2],
                    core_pue[1], core_oe[1], pin_in[1], core_pue[0], core_oe[0], pin_in[0]};

  bst_sync #(.WIDTH(BS_LEN)) u_pin_sync (
    .clk (tck),
    .d   (smp_raw),
    .q   (smp_tck)
  );

  // captured chain image: pad data, pull-up, control and analog side
  assign bs_capture = smp_tck;

  // shift stages, capture and update run on the test clock alone
  always_ff @(posedge tck) begin
    if (tap_reset) begin
      bs_shift_reg <= '0;
    end else if (sel_bs && tap_ctl.capture_dr) begin
      bs_shift_reg <= bs_capture;
    end else if (sel_bs && tap_ctl.shift_dr) begin
      bs_shift_reg <= shr_bs(bs_shift_reg, tdi);
    end
  end

  // output latches; preload under sample keeps them off the pads
  always_ff @(posedge tck) begin
    if (tap_reset) begin
      bs_latch_reg <= '0;
    end else if (sel_bs && tap_ctl.update_dr) begin
      bs_latch_reg <= bs_shift_reg;
    end
  end

  // ----------------------------------------------------------------
  // test data out
  // ----------------------------------------------------------------
  // mux of shift stage outputs; driven only while shifting
  always_comb begin
    case (ir_reg)
      INS_EXTEST, INS_SAMPLE: tdo = bs_shift_reg[0];
      INS_IDCODE:             tdo = id_shift_reg[0];
      INS_FORCE_RST:          tdo = rst_dr_reg;
      default:                tdo = bypass_reg;
    endcase
    if (tap_ctl.shift_ir) begin
      tdo = ir_shift_reg[0];
    end
  end

  assign tdo_oe = tap_en_tck & (tap_ctl.shift_dr | tap_ctl.shift_ir);

  // ----------------------------------------------------------------
  // pads
  // ----------------------------------------------------------------
  // external test overrides the core at once; outside it reset floats every pin output
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (sel_extest) begin
        pin_out[i] = bs_latch_reg[i*CELL_BITS + CELL_DATA];
        pin_oe[i]  = bs_latch_reg[i*CELL_BITS + CELL_OC];
        pin_pue[i] = bs_latch_reg[i*CELL_BITS + CELL_PUE];
      end else begin
        pin_out[i] = core_out[i];
        pin_oe[i]  = core_oe[i] & ~device_reset;
        pin_pue[i] = core_pue[i] & ~device_reset;
      end
    end
    ana_dig_ctl = sel_extest ? bs_latch_reg[BS_ANA_CTL] : core_ana_ctl;
  end

  // inputs pass straight to the core; sampling never disturbs them
  assign core_in     = pin_in;
  assign core_ana_in = ana_dig_in;

  // ----------------------------------------------------------------
  // crossings into the chip clock
  // ----------------------------------------------------------------
  // debugger read event as a toggle
  always_ff @(posedge tck) begin
    if (tap_reset) begin
      dbg_read_tog_reg <= 1'b0;
    end else if (dbg_mbox_read) begin
      dbg_read_tog_reg <= ~dbg_read_tog_reg;
    end
  end

  assign sys_raw = {ext_reset_n, dbg_access_en, dbg_read_tog_reg};

  bst_sync #(.WIDTH(3)) u_sys_sync (
    .clk (clk_sys),
    .d   (sys_raw),
    .q   (sys_sync)
  );

  // reset register level: set at once, released through two flops so that
  // the time-out has taken over before it drops, leaving no gap in reset
  always_ff @(posedge clk_sys or posedge rst_dr_reg) begin
    if (rst_dr_reg) begin
      rst_dr_meta_reg <= 1'b1;
      rst_dr_s        <= 1'b1;
    end else begin
      rst_dr_meta_reg <= 1'b0;
      rst_dr_s        <= rst_dr_meta_reg;
    end
  end

  assign ext_rst_s  = ~sys_sync[2];
  assign dbg_acc_s  = sys_sync[1];
  assign read_tog_s = sys_sync[0];

  // edge of the read toggle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      read_tog_d_reg <= 1'b0;
    end else begin
      read_tog_d_reg <= read_tog_s;
    end
  end

  assign mbox_clear = read_tog_s ^ read_tog_d_reg;

  // ----------------------------------------------------------------
  // debug mailbox
  // ----------------------------------------------------------------
  assign mbox_hit   = io_req.sel & debug_enable_fuse & dbg_acc_s;
  assign io_pass_wr = io_req.sel & io_req.wr & ~mbox_hit;
  assign io_pass_rd = io_req.sel & io_req.rd & ~mbox_hit;

  // byte store
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mbox_reg <= MBOX_RESET;
    end else if (mbox_hit && io_req.wr) begin
      mbox_reg <= io_req.wdata;
    end
  end

  // dirty flag; a write in the clearing cycle keeps it set
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dirty_reg <= 1'b0;
    end else if (mbox_hit && io_req.wr) begin
      dirty_reg <= 1'b1;
    end else if (mbox_clear) begin
      dirty_reg <= 1'b0;
    end
  end

  // cpu read data
  always_comb begin
    if (mbox_hit) begin
      io_rdata                 = mbox_reg;
      io_rdata[MBOX_DIRTY_BIT] = dirty_reg;
    end else begin
      io_rdata = io_pass_rdata;
    end
  end

  // byte goes to the debugger as it stands; a cpu write replaces it even while dirty
  assign dbg_mbox_data = mbox_reg;

  bst_sync #(.WIDTH(1)) u_dirty_sync (
    .clk (tck),
    .d   (dirty_reg),
    .q   (dbg_mbox_dirty)
  );

  // ----------------------------------------------------------------
  // debug fuse programming guard
  // ----------------------------------------------------------------
  // erase remembered until the next system reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      erased_reg <= 1'b0;
    end else if (chip_erase_done) begin
      erased_reg <= 1'b1;
    end
  end

  // one-cycle answers to a programming request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dbg_fuse_prog_grant   <= 1'b0;
      dbg_fuse_prog_refused <= 1'b0;
    end else begin
      dbg_fuse_prog_grant   <= dbg_fuse_prog_req &
                               (~(lock_bit_one | lock_bit_two) | erased_reg);
      dbg_fuse_prog_refused <= dbg_fuse_prog_req &
                               (lock_bit_one | lock_bit_two) & ~erased_reg;
    end
  end

  // ----------------------------------------------------------------
  // device reset and time-out
  // ----------------------------------------------------------------
  assign hold_src = ext_rst_s | rst_dr_s;

  // time-out restarts while a source holds, counts down after release
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rto_busy_reg <= 1'b1;
      rto_cnt_reg  <= RTO_W'(RTO_SHORT_CYC);
    end else if (hold_src) begin
      rto_busy_reg <= 1'b1;
      rto_cnt_reg  <= clk_opt_fuse ? RTO_W'(RTO_LONG_CYC) : RTO_W'(RTO_SHORT_CYC);
    end else if (rto_cnt_reg != '0) begin
      rto_cnt_reg  <= rto_cnt_reg - RTO_W'(1);
    end else begin
      rto_busy_reg <= 1'b0;
    end
  end

  // reset register acts at once, without waiting for the chip clock
  assign device_reset = rst_dr_reg | ext_rst_s | rto_busy_reg;

endmodule // bst_tap
`default_nettype wire

// file: pkg/bst_pkg.sv
// constants and types shared by the boundary-scan test port
package bst_pkg;

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 4'h1;

  typedef enum logic [IR_W-1:0] {
    INS_EXTEST    = 4'h0,
    INS_IDCODE    = 4'h1,
    INS_SAMPLE    = 4'h2,
    INS_FORCE_RST = 4'hc,
    INS_BYPASS    = 4'hf
  } bst_instr_t;

  // ----------------------------------------------------------------
  // identification register layout
  // ----------------------------------------------------------------
  localparam int ID_LEN      = 32;
  localparam int ID_VER_LSB  = 28;
  localparam int ID_PART_LSB = 12;
  localparam int ID_MFR_LSB  = 1;
  localparam logic [3:0]  ID_VERSION = 4'h0;     // arbitrary value
  localparam logic [15:0] ID_PART    = 16'h5a5a; // arbitrary value
  localparam logic [10:0] ID_MFR     = 11'h0a5;  // arbitrary value
  localparam logic        ID_MARKER  = 1'b1;

  // ----------------------------------------------------------------
  // boundary chain layout: three cells per pin, then analog pair
  // ----------------------------------------------------------------
  localparam int NUM_PINS    = 8;
  localparam int CELL_BITS   = 3;
  localparam int CELL_DATA   = 0;
  localparam int CELL_OC     = 1;
  localparam int CELL_PUE    = 2;
  localparam int BS_PIN_BITS = NUM_PINS * CELL_BITS;
  localparam int BS_ANA_CTL  = BS_PIN_BITS;
  localparam int BS_ANA_IN   = BS_PIN_BITS + 1;
  localparam int BS_LEN      = BS_PIN_BITS + 2;

  // ----------------------------------------------------------------
  // debug mailbox
  // ----------------------------------------------------------------
  localparam int MBOX_W         = 8;
  localparam int MBOX_DIRTY_BIT = 7;
  localparam logic [MBOX_W-1:0] MBOX_RESET = 8'h00;

  // ----------------------------------------------------------------
  // reset time-out, chosen by the clock option fuse
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 25;
  localparam int RTO_SHORT_US  = 1;
  localparam int RTO_LONG_US   = 64;
  localparam int RTO_SHORT_CYC = RTO_SHORT_US * CLK_MHZ;
  localparam int RTO_LONG_CYC  = RTO_LONG_US * CLK_MHZ;
  localparam int RTO_W         = 11;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
    logic capture_ir;
    logic shift_ir;
    logic update_ir;
  } bst_tap_ctl_t;

  typedef struct packed {
    logic              sel;
    logic              wr;
    logic              rd;
    logic [MBOX_W-1:0] wdata;
  } bst_io_req_t;

endpackage

// file: core/bst_sync.sv
// two flip-flop level synchroniser, vector wide
`timescale 1ns/1ps
`default_nettype none
module bst_sync #(
  parameter int WIDTH = 1
) (
  // destination clock
  input  wire logic             clk,
  // level in from foreign domain, level out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // first stage is read only by the second
  always_ff @(posedge clk) begin
    meta_reg <= d;
    q        <= meta_reg;
  end

endmodule // bst_sync
`default_nettype wire

// file: verif/bst_jtag_ctrl.sv
// tap controller model driving the test port from outside
`timescale 1ns/1ps
`default_nettype none
module bst_jtag_ctrl
  import bst_pkg::*;
(
  // test clock, strobes and serial lines
  output logic         tck,
  output logic         tap_reset,
  output bst_tap_ctl_t tap_ctl,
  output logic         tdi,
  input  wire logic    tdo,
  // debugger side of the mailbox
  output logic         dbg_access_en,
  output logic         dbg_mbox_read
);
  // tck stands low between frames
  initial begin
    tck = 1'b0;
    tap_reset = 1'b1;
    tap_ctl = '0;
    tdi = 1'b0;
    dbg_access_en = 1'b1;
    dbg_mbox_read = 1'b0;
  end
  // one 12 ns period, tdo taken just before the rising edge
  task automatic tick(input bst_tap_ctl_t c, input logic d, output logic q);
    tap_ctl = c;
    tdi = d;
    #5 q = tdo;
    #1 tck = 1'b1;
    #6 tck = 1'b0;
  endtask
  task automatic treset();
    logic q;
    tap_reset = 1'b1;
    repeat (3) tick('0, ~tdi, q);
    tap_reset = 1'b0;
  endtask
  // capture, n shifts, update, idle; idle tdi flips so nothing stale lingers
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    tick(ir ? 6'h04 : 6'h20, ~tdi, q);
    for (int i = 0; i < n; i++) begin
      tick(ir ? 6'h02 : 6'h10, din[i], q);
      dout[i] = q;
    end
    tick(ir ? 6'h01 : 6'h08, ~din[n-1], q);
    tick('0, din[n-1], q);
  endtask
  // debugger has taken the mailbox byte
  task automatic ack();
    logic q;
    dbg_mbox_read = 1'b1;
    tick('0, ~tdi, q);
    dbg_mbox_read = 1'b0;
  endtask
endmodule // bst_jtag_ctrl
`default_nettype wire

// file: verif/bst_tap_properties.sv
// concurrent checks on the test port's pins
`timescale 1ns/1ps
`default_nettype none
module bst_tap_properties
  import bst_pkg::*;
(
  input wire logic              clk_sys, rst, tck, tap_reset, tdo, tap_enabled,
  input wire logic              test_port_enable_fuse, test_port_disable_bit, debug_enable_fuse,
  input wire logic              lock_bit_one, lock_bit_two, dbg_fuse_prog_req, chip_erase_done,
  input wire logic              dbg_fuse_prog_refused, io_pass_wr, io_pass_rd,
  input wire logic              ext_reset_n, device_reset, tdo_oe,
  input wire bst_tap_ctl_t      tap_ctl,
  input wire bst_io_req_t       io_req,
  input wire logic [MBOX_W-1:0] io_rdata, dbg_mbox_data
);
  // lock guard lifts only after an erase since reset
  logic erased_reg;
  always_ff @(posedge clk_sys) begin
    if (rst) erased_reg <= 1'b0;
    else if (chip_erase_done) erased_reg <= 1'b1;
  end
  a_tap_enable: assert property (@(posedge clk_sys) disable iff (rst)
    tap_enabled == (test_port_enable_fuse && !test_port_disable_bit)) else $error("enable");
  a_mbox_store: assert property (@(posedge clk_sys) disable iff (rst)
    io_req.sel && io_req.wr && !io_pass_wr |=> dbg_mbox_data == $past(io_req.wdata))
    else $error("mailbox store");
  a_mbox_read: assert property (@(posedge clk_sys) disable iff (rst)
    io_req.sel && io_req.wr && !io_pass_wr ##1 io_req.sel && io_req.rd && !io_pass_rd
    |-> io_rdata == {1'b1, $past(io_req.wdata[6:0])}) else $error("mailbox read");
  a_mbox_route: assert property (@(posedge clk_sys) disable iff (rst)
    !debug_enable_fuse && io_req.sel && io_req.wr |-> io_pass_wr) else $error("route");
  a_lock_refuse: assert property (@(posedge clk_sys) disable iff (rst)
    dbg_fuse_prog_req && (lock_bit_one || lock_bit_two) && !erased_reg && !chip_erase_done
    |=> dbg_fuse_prog_refused) else $error("lock refuse");
  a_pin_reset: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(ext_reset_n) |-> ##[1:3] device_reset) else $error("pin reset");
  a_reset_hold: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(ext_reset_n) |=> device_reset [*8]) else $error("reset hold");
  a_ir_capture: assert property (@(posedge tck) disable iff (tap_reset)
    tap_ctl.capture_ir && tap_enabled |=> tdo) else $error("ir capture");
  a_tdo_drive: assert property (@(posedge tck) disable iff (tap_reset)
    tap_ctl.shift_dr || tap_ctl.shift_ir |-> tdo_oe) else $error("tdo drive");
endmodule // bst_tap_properties
bind bst_tap bst_tap_properties u_props (.*);
`default_nettype wire

// file: verif/boundary_scan_test_port_tb_top.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_test_port_tb_top;
  import bst_pkg::*;
  logic clk_sys, rst, tck, tap_reset, tdi, tdo, tdo_oe, dbg_access_en, dbg_mbox_read;
  logic test_port_enable_fuse, debug_enable_fuse, lock_bit_one, lock_bit_two, clk_opt_fuse;
  logic dbg_fuse_prog_req, chip_erase_done, dbg_fuse_prog_grant, dbg_fuse_prog_refused;
  logic csr_wr, csr_wdata_disable, test_port_disable_bit, tap_enabled, io_pass_wr, io_pass_rd;
  logic dbg_mbox_dirty, ext_reset_n, device_reset, core_ana_ctl, core_ana_in, ana_dig_in;
  logic ana_dig_ctl;
  logic [7:0] io_rdata, io_pass_rdata, dbg_mbox_data, core_out, core_oe, core_pue, core_in;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pue, pat;
  logic [31:0] d, v;
  bst_tap_ctl_t tap_ctl;
  bst_io_req_t io_req;
  int bad_count, checked, cyc, n;

  bst_tap DUT (.*);
  bst_jtag_ctrl u_ctrl (.*);

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // hang guard, far above the longest reset time-out
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  // ----------------------------------------------------------------
  // helpers and scenarios
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_run(output int k);
    k = 0;
    while (device_reset === 1'b1 && k < 4000) begin
      @(negedge clk_sys);
      k++;
    end
  endtask
  task automatic finish_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic t_enable();
    @(posedge clk_sys);
    csr_wr <= 1'b1;
    csr_wdata_disable <= 1'b1;
    @(posedge clk_sys);
    csr_wdata_disable <= 1'b0;
    #1 chk(tap_enabled, 0);
    @(posedge clk_sys);
    csr_wr <= 1'b0;
    test_port_enable_fuse <= 1'b0;
    #1 chk(tap_enabled, 0);
    @(posedge clk_sys);
    test_port_enable_fuse <= 1'b1;
    #1 chk(tap_enabled, 1);
    u_ctrl.treset();
  endtask
  task automatic t_scan();
    u_ctrl.scan(1'b0, 32, 32'h0, d);
    chk(d, {ID_VERSION, ID_PART, ID_MFR, ID_MARKER});
    u_ctrl.scan(1'b1, 4, 32'h0000_000f, d);
    chk(d[3:0], IR_CAPTURE_VAL);
    u_ctrl.scan(1'b0, 4, 32'h0000_000f, d);
    chk(d[3:0], 4'he);
  endtask
  task automatic t_mbox();
    @(posedge clk_sys);
    io_req <= '{sel: 1'b1, wr: 1'b1, rd: 1'b0, wdata: 8'h43};
    io_pass_rdata <= 8'h3c;
    @(posedge clk_sys);
    io_req <= '{sel: 1'b1, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    #1 chk(io_rdata, 8'hc3);
    @(posedge clk_sys);
    io_req <= '0;
    u_ctrl.scan(1'b0, 1, 32'h0000_0000, d);
    chk(dbg_mbox_dirty, 1);
    u_ctrl.ack();
    repeat (8) @(posedge clk_sys);
    io_req <= '{sel: 1'b1, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    #1 chk(io_rdata, 8'h43);
    @(posedge clk_sys);
    io_req <= '{sel: 1'b1, wr: 1'b1, rd: 1'b1, wdata: 8'h11};
    debug_enable_fuse <= 1'b0;
    #1 chk({io_pass_wr, io_pass_rd, io_rdata}, 10'h33c);
    @(posedge clk_sys);
    io_req <= '0;
    debug_enable_fuse <= 1'b1;
    #1 chk(dbg_mbox_data, 8'h43);
    u_ctrl.scan(1'b0, 1, 32'h0000_0000, d);
    chk(dbg_mbox_dirty, 0);
  endtask
  task automatic t_fuse();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      lock_bit_one <= (i != 0);
      lock_bit_two <= (i == 0);
      chip_erase_done <= (i == 2);
      @(posedge clk_sys);
      chip_erase_done <= 1'b0;
      dbg_fuse_prog_req <= 1'b1;
      @(posedge clk_sys);
      dbg_fuse_prog_req <= 1'b0;
      #1 chk({dbg_fuse_prog_grant, dbg_fuse_prog_refused}, (i == 2) ? 2'h2 : 2'h1);
    end
  endtask
  task automatic t_reset();
    u_ctrl.scan(1'b1, 4, {28'h000_0000, INS_FORCE_RST}, d);
    u_ctrl.scan(1'b0, 1, 32'h0000_0001, d);
    #1 chk({device_reset, pin_oe}, 9'h100);
    u_ctrl.scan(1'b0, 1, 32'h0000_0000, d);
    wait_run(n);
    chk(n >= RTO_SHORT_CYC && n < RTO_SHORT_CYC + 8, 1);
    @(posedge clk_sys);
    ext_reset_n <= 1'b0;
    clk_opt_fuse <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ext_reset_n <= 1'b1;
    #1 chk(device_reset, 1);
    wait_run(n);
    chk(n >= RTO_LONG_CYC && n < RTO_LONG_CYC + 8, 1);
  endtask
  task automatic t_extest();
    @(posedge clk_sys);
    pin_in <= 8'h96;
    v = 32'h0100_0000;
    pat = 8'h5a;
    for (int i = 0; i < NUM_PINS; i++) v[3*i +: 3] = {1'b0, 1'b1, pat[i]};
    u_ctrl.scan(1'b1, 4, {28'h000_0000, INS_SAMPLE}, d);
    u_ctrl.scan(1'b0, BS_LEN, v, d);
    for (int i = 0; i < NUM_PINS; i++) pat[i] = d[3*i];
    chk({pat, pin_out}, {8'h96, core_out});
    u_ctrl.scan(1'b1, 4, {28'h000_0000, INS_EXTEST}, d);
    chk({pin_out, pin_oe, pin_pue}, {8'h5a, 8'hff, 8'h00});
    chk({ana_dig_ctl, core_ana_in, core_in}, {1'b1, 1'b0, 8'h96});
  endtask
  // reset, then the scenarios in turn
  initial begin
    rst = 1'b1;
    ext_reset_n = 1'b1;
    test_port_enable_fuse = 1'b1;
    debug_enable_fuse = 1'b1;
    {lock_bit_one, lock_bit_two, clk_opt_fuse, dbg_fuse_prog_req, chip_erase_done} = '0;
    {csr_wr, csr_wdata_disable, core_ana_ctl, ana_dig_in} = '0;
    io_req = '0;
    io_pass_rdata = 8'h00;
    pin_in = 8'h00;
    core_out = 8'h33;
    core_oe = 8'hff;
    core_pue = 8'h00;
    u_ctrl.treset(); // test clock logic known before the chip leaves reset
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    wait_run(n);
    t_enable();
    t_scan();
    t_mbox();
    t_fuse();
    t_reset();
    t_extest();
    finish_test();
  end
endmodule // boundary_scan_test_port_tb_top
`default_nettype wire
